// [pkg/ifpb_pkg.sv]
/*
  Package for the interrupt flag and priority bank: register indices,
  field positions, reset values and the bus request carrier.
  Assumes a 32-bit Avalon-MM slave whose address is the register byte offset itself.
*/
package ifpb_pkg;
  // register byte offsets
  localparam logic [4:0] OFF_FLAGS0 = 5'h00;
  localparam logic [4:0] OFF_FLAGS1 = 5'h04;
  localparam logic [4:0] OFF_PRIO_CAP = 5'h08;
  localparam logic [4:0] OFF_PRIO_T6 = 5'h0c;
  localparam logic [4:0] OFF_PRIO_UERR = 5'h10;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h18;
  localparam logic [4:0] OFF_MAX_PRIO = 5'h1c;
  localparam int NUM_REGS = 8;
  // flag bit positions
  localparam int BIT_DMA1 = 14;
  localparam int BIT_SPI1 = 10;
  localparam int BIT_TMR3 = 8;
  localparam int BIT_TMR2 = 7;
  localparam int BIT_TMR1 = 3;
  localparam int BIT_TMR5 = 12;
  localparam int BIT_TMR4 = 11;
  // implemented flag bits; bit 15 of flags 0 and bit 2 of flags 1 are holes
  localparam logic [15:0] FLAGS0_IMPL = 16'h7fff;
  localparam logic [15:0] FLAGS1_IMPL = 16'hfffb;
  // implemented priority fields per register
  localparam logic [15:0] PRIO_CAP_IMPL = 16'h7777;
  localparam logic [15:0] PRIO_T6_IMPL = 16'h7707;
  localparam logic [15:0] PRIO_UERR_IMPL = 16'h0770;
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [2:0] PRIO_TOP = 3'h7;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  // uart2 error field lsb within its register
  localparam int UERR2_LSB = 8;
  // status / mask bits of the interrupt line
  localparam int IRQ_F0 = 0;
  localparam int IRQ_F1 = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // bus request carrier
  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } ifpb_req_t;

  // per-source event pulses from peripherals
  typedef struct packed {
    logic [15:0] flags0;
    logic [15:0] flags1;
  } ifpb_evt_t;
endpackage

// [design/ifpb_regmem.sv]
/*
  Small register memory holding the three priority control words.
  Assumes one synchronous write port and registered read data.
*/
`timescale 1ns/1ps
module ifpb_regmem
  import ifpb_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] rd_idx,
  output logic [15:0] rd_data,
  output logic [47:0] all_words
);
  logic [15:0] mem_reg [0:2];

  // implemented-bit mask of each word
  function automatic logic [15:0] impl_mask(input logic [1:0] idx);
    case (idx)
      2'h0: impl_mask = PRIO_CAP_IMPL;
      2'h1: impl_mask = PRIO_T6_IMPL;
      2'h2: impl_mask = PRIO_UERR_IMPL;
      default: impl_mask = 16'h0000;
    endcase
  endfunction

  // every implemented field resets to level four
  function automatic logic [15:0] reset_word(input logic [1:0] idx);
    reset_word = impl_mask(idx) & {4{1'b0, PRIO_RESET}};
  endfunction

  // storage; unimplemented bits never hold a one
  always_ff @(posedge mclk) begin
    if (srst) begin
      mem_reg[0] <= reset_word(2'h0);
      mem_reg[1] <= reset_word(2'h1);
      mem_reg[2] <= reset_word(2'h2);
    end else if (wr_en && wr_idx != 2'h3) begin
      mem_reg[wr_idx] <= wr_data & impl_mask(wr_idx);
    end
  end

  // registered read port
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_data <= 16'h0000;
    end else if (rd_idx == 2'h3) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= mem_reg[rd_idx];
    end
  end

  assign all_words = {mem_reg[2], mem_reg[1], mem_reg[0]};
endmodule

// [design/ifpb_bank.sv]
/*
  Interrupt flag and priority bank: two flag words set by peripheral
  events, three priority control words, and an interrupt line.
  Assumes an Avalon-MM master on mclk and one-cycle event pulses.
*/
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module ifpb_bank
  import ifpb_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic dma_ch1_done_flag,
  input wire logic serial_port1_event_flag,
  input wire logic timer3_flag,
  input wire logic timer2_flag,
  input wire logic timer1_flag,
  input wire logic timer5_flag,
  input wire logic timer4_flag,
  input wire ifpb_pkg::ifpb_evt_t other_events,
  output logic [15:0] interrupt_flags_0,
  output logic [15:0] interrupt_flags_1,
  output logic [2:0] uart2_error_priority,
  output logic [2:0] top_pending_level,
  output logic irq
);
  import ifpb_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_DONE = 2'b10
  } ifpb_state_t;

  ifpb_state_t state_reg;
  ifpb_req_t req;
  logic [15:0] flags0_reg;
  logic [15:0] flags1_reg;
  logic [15:0] flags0_next;
  logic [15:0] flags1_next;
  logic [15:0] set0;
  logic [15:0] set1;
  logic [1:0] stat_reg;
  logic [1:0] mask_reg;
  logic [2:0] maxp_reg;
  logic [15:0] prio_rd;
  logic [47:0] prio_words;
  logic wr_take;
  logic rd_take;
  logic lo_en;
  logic hi_en;
  logic [15:0] wdata;

  // map a flag bit to its priority code (bits 0..3 use bits 2:0 of word 0, all others level 4)
  function automatic logic [2:0] bit_prio(input logic [47:0] w,
                                          input int b);
    bit_prio = (b < 4) ? w[2:0] : PRIO_RESET;
  endfunction

  // decode a byte address to a priority word index
  function automatic logic [1:0] prio_idx(input logic [4:0] a);
    case (a)
      OFF_PRIO_CAP: prio_idx = 2'h0;
      OFF_PRIO_T6: prio_idx = 2'h1;
      OFF_PRIO_UERR: prio_idx = 2'h2;
      default: prio_idx = 2'h3;
    endcase
  endfunction

  // gather bus request into the carrier
  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 byteenable: avs_byteenable, writedata: avs_writedata};
  assign wr_take = req.write && state_reg == ST_IDLE;
  assign rd_take = req.read && state_reg == ST_DONE;
  assign lo_en = req.byteenable[0];
  assign hi_en = req.byteenable[1];
  assign wdata = req.writedata[15:0];

  // event pulses mapped onto flag positions
  always_comb begin
    set0 = other_events.flags0 & FLAGS0_IMPL;
    set1 = other_events.flags1 & FLAGS1_IMPL;
    set0[BIT_DMA1] = set0[BIT_DMA1] | dma_ch1_done_flag;
    set0[BIT_SPI1] = set0[BIT_SPI1] | serial_port1_event_flag;
    set0[BIT_TMR3] = set0[BIT_TMR3] | timer3_flag;
    set0[BIT_TMR2] = set0[BIT_TMR2] | timer2_flag;
    set0[BIT_TMR1] = set0[BIT_TMR1] | timer1_flag;
    set1[BIT_TMR5] = set1[BIT_TMR5] | timer5_flag;
    set1[BIT_TMR4] = set1[BIT_TMR4] | timer4_flag;
  end

  // software write with byte lanes; a new event wins over the write
  always_comb begin
    flags0_next = flags0_reg;
    flags1_next = flags1_reg;
    if (wr_take && req.address == OFF_FLAGS0) begin
      if (lo_en) flags0_next[7:0] = wdata[7:0];
      if (hi_en) flags0_next[15:8] = wdata[15:8];
    end
    if (wr_take && req.address == OFF_FLAGS1) begin
      if (lo_en) flags1_next[7:0] = wdata[7:0];
      if (hi_en) flags1_next[15:8] = wdata[15:8];
    end
    flags0_next = (flags0_next | set0) & FLAGS0_IMPL;
    flags1_next = (flags1_next | set1) & FLAGS1_IMPL;
  end

  // flag storage
  always_ff @(posedge mclk) begin
    if (srst) begin
      flags0_reg <= FLAGS_RESET;
      flags1_reg <= FLAGS_RESET;
    end else begin
      flags0_reg <= flags0_next;
      flags1_reg <= flags1_next;
    end
  end

  // priority words live in the small memory
  ifpb_regmem u_mem (
    .mclk(mclk),
    .srst(srst),
    .wr_en(wr_take && lo_en && hi_en),
    .wr_idx(prio_idx(req.address)),
    .wr_data(wdata),
    .rd_idx(prio_idx(req.address)),
    .rd_data(prio_rd),
    .all_words(prio_words)
  );

  // bus handshake: write answers in one wait cycle, read in two
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (req.write) state_reg <= ST_DONE;
          else if (req.read) state_reg <= ST_READ;
        end
        ST_READ: state_reg <= ST_DONE;
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // waitrequest low only in the answer cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(state_reg == ST_READ ||
                           (state_reg == ST_IDLE && req.write));
    end
  end

  // read data; unmapped addresses read zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      avs_readdata <= 32'h00000000;
    end else if (state_reg == ST_READ) begin
      case (req.address)
        OFF_FLAGS0: avs_readdata <= {16'h0000, flags0_reg};
        OFF_FLAGS1: avs_readdata <= {16'h0000, flags1_reg};
        OFF_PRIO_CAP, OFF_PRIO_T6, OFF_PRIO_UERR:
          avs_readdata <= {16'h0000, prio_rd};
        OFF_IRQ_STAT: avs_readdata <= {30'h0, stat_reg};
        OFF_IRQ_MASK: avs_readdata <= {30'h0, mask_reg};
        OFF_MAX_PRIO: avs_readdata <= {29'h0, maxp_reg};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // sticky status: any flag newly set by an event; a read clears only the bits it
  // returned, so a set landing after the data was taken is not lost
  always_ff @(posedge mclk) begin
    if (srst) begin
      stat_reg <= IRQ_RESET;
    end else begin
      stat_reg[IRQ_F0] <= (|(set0 & ~flags0_reg)) |
        (stat_reg[IRQ_F0] & !(rd_take && req.address == OFF_IRQ_STAT &&
                              avs_readdata[IRQ_F0]));
      stat_reg[IRQ_F1] <= (|(set1 & ~flags1_reg)) |
        (stat_reg[IRQ_F1] & !(rd_take && req.address == OFF_IRQ_STAT &&
                              avs_readdata[IRQ_F1]));
    end
  end

  // mask register
  always_ff @(posedge mclk) begin
    if (srst) begin
      mask_reg <= IRQ_RESET;
    end else if (wr_take && req.address == OFF_IRQ_MASK && lo_en) begin
      mask_reg <= wdata[1:0];
    end
  end

  // while any flag is pending, the level in bits 2:0 of priority word 0
  always_ff @(posedge mclk) begin
    if (srst) begin
      maxp_reg <= PRIO_OFF;
    end else begin
      maxp_reg <= (|flags0_reg | |flags1_reg) ?
                  bit_prio(prio_words, 0) : PRIO_OFF;
    end
  end

  // outputs from flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      interrupt_flags_0 <= FLAGS_RESET;
      interrupt_flags_1 <= FLAGS_RESET;
      uart2_error_priority <= PRIO_RESET;
      top_pending_level <= PRIO_OFF;
      irq <= 1'b0;
    end else begin
      interrupt_flags_0 <= flags0_next;
      interrupt_flags_1 <= flags1_next;
      uart2_error_priority <=
        prio_words[32 + UERR2_LSB +: 3];
      top_pending_level <= maxp_reg;
      irq <= |(stat_reg & mask_reg);
    end
  end

  a_timer1_sets: assert property (
    @(posedge mclk) disable iff (srst)
    timer1_flag |=> flags0_reg[BIT_TMR1])
    else $error("timer1 flag not set");
  a_timer2_sets: assert property (
    @(posedge mclk) disable iff (srst)
    timer2_flag |=> flags0_reg[BIT_TMR2])
    else $error("timer2 flag not set");
  a_timer3_sets: assert property (
    @(posedge mclk) disable iff (srst)
    timer3_flag |=> flags0_reg[BIT_TMR3])
    else $error("timer3 flag not set");
  a_timer4_sets: assert property (
    @(posedge mclk) disable iff (srst)
    timer4_flag |=> interrupt_flags_1[BIT_TMR4])
    else $error("timer4 flag not visible");
  a_timer5_sets: assert property (
    @(posedge mclk) disable iff (srst)
    timer5_flag |=> flags1_reg[BIT_TMR5])
    else $error("timer5 flag not set");
  a_spi_event_sets: assert property (
    @(posedge mclk) disable iff (srst)
    serial_port1_event_flag |=> flags0_reg[BIT_SPI1])
    else $error("serial port flag not set");
  a_dma_done_sets: assert property (
    @(posedge mclk) disable iff (srst)
    dma_ch1_done_flag |=> flags0_reg[BIT_DMA1])
    else $error("dma flag not set");
  a_flag_holds: assert property (
    @(posedge mclk) disable iff (srst)
    flags0_reg[BIT_TMR1] && !wr_take |=> flags0_reg[BIT_TMR1])
    else $error("flag dropped without write");
  a_holes_zero: assert property (
    @(posedge mclk) disable iff (srst)
    (prio_words[15:0] & ~PRIO_CAP_IMPL) == 16'h0000)
    else $error("unimplemented priority bit set");
  a_reset_prio: assert property (
    @(posedge mclk)
    srst |=> prio_words[42:40] == PRIO_RESET)
    else $error("uart2 priority not 100 after reset");
  a_irq_level: assert property (
    @(posedge mclk) disable iff (srst)
    |(stat_reg & mask_reg) |=> irq)
    else $error("irq missing");
  a_uerr_field: assert property (
    @(posedge mclk) disable iff (srst)
    1'b1 |=> uart2_error_priority == $past(prio_words[42:40]))
    else $error("uart2 priority field wrong");

  c_write_flags: cover property (@(posedge mclk) wr_take &&
    req.address == OFF_FLAGS0);
  c_read_done: cover property (@(posedge mclk) rd_take);
  c_irq_rise: cover property (@(posedge mclk) $rose(irq));
  c_top_level: cover property (@(posedge mclk) maxp_reg == PRIO_TOP);
endmodule

// [sim/ifpb_src_model.sv]
/*
  Model of the peripheral event sources feeding the flag bank.
  Assumes the bench calls its tasks just after a rising mclk edge.
*/
`timescale 1ns/1ps
module ifpb_src_model
  import ifpb_pkg::*;
(
  input wire logic mclk,
  output logic [6:0] named_pulse,
  output ifpb_pkg::ifpb_evt_t other_pulse
);
  import ifpb_pkg::*;
  initial begin
    named_pulse = '0;
    other_pulse = '0;
  end
  // one-cycle request: dma1, spi1, tmr3, tmr2, tmr1, tmr5, tmr4
  task automatic fire(input int i);
    @(posedge mclk);
    named_pulse[i] <= 1'b1;
    @(posedge mclk);
    named_pulse[i] <= 1'b0;
  endtask
  // one-cycle request on any of the remaining sources
  task automatic fire_other(input ifpb_evt_t v);
    @(posedge mclk);
    other_pulse <= v;
    @(posedge mclk);
    other_pulse <= '0;
  endtask
endmodule

// [sim/testbench.sv]
/*
  Self-checking bench for the flag and priority bank.
  Assumes the Avalon-MM timing of the bank and the event source model.
*/
`timescale 1ns/1ps
module testbench;
  import ifpb_pkg::*;
  logic mclk = 0;
  logic srst = 1;
  logic [4:0] avs_address = '0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [6:0] ev;
  ifpb_evt_t oev;
  logic [15:0] f0, f1;
  logic [2:0] u2p, tpl;
  logic irq;
  int n_errors = 0;
  int samples_checked = 0;
  logic [31:0] exp_flags;
  logic [4:0] ev_off [7] = '{OFF_FLAGS0, OFF_FLAGS0, OFF_FLAGS0,
    OFF_FLAGS0, OFF_FLAGS0, OFF_FLAGS1, OFF_FLAGS1};
  int ev_bit [7] = '{BIT_DMA1, BIT_SPI1, BIT_TMR3, BIT_TMR2, BIT_TMR1,
    BIT_TMR5, BIT_TMR4};
  // clock of 100 ns
  always #50 mclk = ~mclk;
  ifpb_src_model src (.mclk(mclk), .named_pulse(ev), .other_pulse(oev));
  ifpb_bank dut (.mclk(mclk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dma_ch1_done_flag(ev[0]), .serial_port1_event_flag(ev[1]),
    .timer3_flag(ev[2]), .timer2_flag(ev[3]), .timer1_flag(ev[4]),
    .timer5_flag(ev[5]), .timer4_flag(ev[6]), .other_events(oev),
    .interrupt_flags_0(f0), .interrupt_flags_1(f1),
    .uart2_error_priority(u2p), .top_pending_level(tpl), .irq(irq));
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // returns at the rising edge at which waitrequest is sampled low
  task automatic wait_answer();
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
  endtask
  // request stands until the answer edge; one idle edge follows
  task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= 1'b1;
    wait_answer();
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  // read data taken at the answer edge itself
  task automatic bus_rd(input logic [4:0] a, input logic [15:0] exp);
    logic [31:0] d;
    avs_address <= a;
    avs_read <= 1'b1;
    wait_answer();
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge mclk);
    check(d, {16'h0000, exp});
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    // reset values
    bus_rd(OFF_FLAGS0, 16'h0000);
    bus_rd(OFF_FLAGS1, 16'h0000);
    bus_rd(OFF_PRIO_CAP, 16'h4444);
    bus_rd(OFF_PRIO_T6, 16'h4404);
    bus_rd(OFF_PRIO_UERR, 16'h0440);
    check({29'h0, u2p}, 32'h4);
    check({31'h0, irq}, 32'h0);
    $display("test reset done");
    // each named source sets its own bit, software clears it
    for (int i = 0; i < 7; i++) begin
      src.fire(i);
      bus_rd(ev_off[i], 16'h1 << ev_bit[i]);
      exp_flags = (ev_off[i] == OFF_FLAGS0) ?
        {16'h0000, 16'h1 << ev_bit[i]} : {16'h1 << ev_bit[i], 16'h0000};
      check({f1, f0}, exp_flags);
      bus_wr(ev_off[i], 16'h0000);
      bus_rd(ev_off[i], 16'h0000);
    end
    src.fire_other('{flags0: 16'h0000, flags1: 16'h0001});
    bus_rd(OFF_FLAGS1, 16'h0001);
    bus_wr(OFF_FLAGS1, 16'h0000);
    $display("test events done");
    // interrupt line: clear status, unmask, raise, read-clear, mask
    bus_rd(OFF_IRQ_STAT, 16'h0003);
    bus_rd(OFF_IRQ_STAT, 16'h0000);
    bus_wr(OFF_IRQ_MASK, 16'h0003);
    src.fire(4);
    repeat (3) @(posedge mclk);
    check({31'h0, irq}, 32'h1);
    check({29'h0, tpl}, 32'h4);
    bus_rd(OFF_IRQ_STAT, 16'h0001);
    repeat (3) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    bus_wr(OFF_IRQ_MASK, 16'h0000);
    src.fire(5);
    repeat (3) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    bus_rd(OFF_IRQ_STAT, 16'h0002);
    $display("test interrupt done");
    // priority fields, holes, byte lanes and unimplemented bits
    bus_wr(OFF_PRIO_UERR, 16'h0770);
    @(posedge mclk);
    check({29'h0, u2p}, {29'h0, PRIO_TOP});
    bus_wr(OFF_PRIO_UERR, 16'hffff);
    bus_rd(OFF_PRIO_UERR, 16'h0770);
    bus_wr(OFF_PRIO_UERR, 16'h0000);
    @(posedge mclk);
    check({29'h0, u2p}, {29'h0, PRIO_OFF});
    bus_wr(OFF_PRIO_CAP, 16'hffff);
    bus_rd(OFF_PRIO_CAP, 16'h7777);
    bus_wr(OFF_PRIO_T6, 16'hffff);
    bus_rd(OFF_PRIO_T6, 16'h7707);
    bus_wr(OFF_FLAGS0, 16'hffff);
    bus_rd(OFF_FLAGS0, 16'h7fff);
    // low byte lane alone clears only flags 7..0
    avs_byteenable <= 4'h1;
    bus_wr(OFF_FLAGS0, 16'h0000);
    avs_byteenable <= 4'hf;
    bus_rd(OFF_FLAGS0, 16'h7f00);
    bus_wr(OFF_FLAGS1, 16'hffff);
    bus_rd(OFF_FLAGS1, 16'hfffb);
    bus_rd(OFF_MAX_PRIO, {13'h0, PRIO_TOP});
    bus_rd(5'h1e, 16'h0000);
    $display("test priority done");
    // a second reset in mid-run restores everything
    srst <= 1'b1;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    bus_rd(OFF_FLAGS0, 16'h0000);
    bus_rd(OFF_PRIO_T6, 16'h4404);
    check({29'h0, u2p}, {29'h0, PRIO_RESET});
    $display("test second reset done");
    complete_run();
  end
endmodule
